/* rtl/ama_arbiter.sv */
// auto/manual speed reference arbiter with axi4-lite registers
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
module ama_arbiter #(
    parameter int N = ama_pkg::NPORT
) (
    // clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // axi4-lite write address
    input  wire logic [ama_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // axi4-lite read address
    input  wire logic [ama_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // terminal pins
    input  wire logic [N-1:0]                term_toggle,
    input  wire logic                        am_input,
    // port conditions from drive logic
    input  wire logic [N-1:0]                term_legacy,
    input  wire logic [N-1:0]                term_comm_loss,
    input  wire logic [N-1:0]                term_logout,
    input  wire logic [N-1:0]                local_owned,
    input  wire logic                        ref_claim,
    // reference sources
    input  wire logic [ama_pkg::REF_W-1:0]   auto_ref,
    input  wire logic [ama_pkg::WSRC_NUM-1:0][ama_pkg::REF_W-1:0] wired_src,
    // arbiter outputs
    output logic [ama_pkg::REF_W-1:0]        speed_ref,
    output logic [N-1:0]                     term_manual,
    output logic                             wired_manual
);
    localparam int IW    = (N > 1) ? $clog2(N) : 1;
    localparam int RW    = ama_pkg::REF_W;
    localparam logic [ama_pkg::CTRL_SEL_W:0] RST_CTRL_SLICE =
        ama_pkg::RST_CTRL[ama_pkg::CTRL_SEL_W:0];

    typedef struct packed {
        ama_pkg::ama_own_e             own;
        logic [IW-1:0]                 idx;
        logic                          latched;
        logic [RW-1:0]                 latch_val;
        logic [RW-1:0]                 speed;
        logic [N-1:0]                  term_man;
        logic                          wired_man;
        logic [N-1:0][RW-1:0]          term_ref;
        ama_pkg::ama_ctrl_s            ctrl;
        logic [N-1:0]                  ref_mask;
        logic [N-1:0]                  logic_mask;
        logic [N-1:0]                  assigned;
        logic                          aw_got;
        logic [ama_pkg::ADDR_W-1:0]    awaddr;
        logic                          w_got;
        logic [31:0]                   wdata;
        logic [3:0]                    wstrb;
        logic                          awready;
        logic                          wready;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arready;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
    } ama_state_s;

    ama_state_s st_r;
    ama_state_s st_nxt;

    logic [N-1:0] tog_rise;
    logic         am_level;
    logic         am_rise;

    ama_edge_sync #(.W(N)) u_term_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (term_toggle),
        .level   (),
        .rise    (tog_rise)
    );

    ama_edge_sync #(.W(1)) u_wired_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (am_input),
        .level   (am_level),
        .rise    (am_rise)
    );

    function automatic logic [N-1:0] onehot(input logic [IW-1:0] i);
        logic [N-1:0] v;
        v = '0;
        v[i] = 1'b1;
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] v;
        v = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                v[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return v;
    endfunction

    function automatic logic [ama_pkg::ADDR_W-1:0] term_addr(input int i);
        return ama_pkg::ADDR_TERM_REF + ama_pkg::TERM_REF_STRIDE * ama_pkg::ADDR_W'(i);
    endfunction

    logic [N-1:0]  eligible;
    logic          grant_term;
    logic [IW-1:0] grant_idx;
    logic          release_now;
    logic          restore;
    logic [31:0]   ctrl_word;
    logic [31:0]   rd_word;
    logic          rd_hit;
    logic          wr_hit;
    logic [31:0]   wr_val;
    logic [RW-1:0] wired_val;

    always_comb begin
        st_nxt      = st_r;
        eligible    = '0;
        grant_term  = 1'b0;
        grant_idx   = '0;
        release_now = 1'b0;
        restore     = 1'b0;
        rd_word     = '0;
        rd_hit      = 1'b0;
        wr_hit      = 1'b0;
        wr_val      = '0;
        ctrl_word   = '0;
        ctrl_word[ama_pkg::CTRL_PRELOAD_BIT] = st_r.ctrl.preload_en;
        ctrl_word[ama_pkg::CTRL_SEL_LSB +: ama_pkg::CTRL_SEL_W] = st_r.ctrl.wsel;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            wr_hit        = 1'b1;
            st_nxt.bresp  = ama_pkg::RESP_OKAY;
            case (st_r.awaddr)
                ama_pkg::ADDR_CTRL: begin
                    wr_val = merge(ctrl_word, st_r.wdata, st_r.wstrb);
                    st_nxt.ctrl.preload_en = wr_val[ama_pkg::CTRL_PRELOAD_BIT];
                    st_nxt.ctrl.wsel = ama_pkg::ama_wsrc_e'(
                        wr_val[ama_pkg::CTRL_SEL_LSB +: ama_pkg::CTRL_SEL_W]);
                    restore = wr_val[ama_pkg::CTRL_RESTORE_BIT];
                end
                ama_pkg::ADDR_REF_MASK: begin
                    wr_val = merge(32'(st_r.ref_mask), st_r.wdata, st_r.wstrb);
                    st_nxt.ref_mask = wr_val[N-1:0];
                end
                ama_pkg::ADDR_LOGIC_MASK: begin
                    wr_val = merge(32'(st_r.logic_mask), st_r.wdata, st_r.wstrb);
                    st_nxt.logic_mask = wr_val[N-1:0];
                end
                ama_pkg::ADDR_ASSIGNED: begin
                    wr_val = merge(32'(st_r.assigned), st_r.wdata, st_r.wstrb);
                    st_nxt.assigned = wr_val[N-1:0];
                end
                ama_pkg::ADDR_STATUS, ama_pkg::ADDR_SPEED: begin
                    wr_val = '0;
                end
                default: begin
                    wr_hit = 1'b0;
                    for (int i = 0; i < N; i++) begin
                        if (st_r.awaddr == term_addr(i)) begin
                            wr_hit = 1'b1;
                            wr_val = merge(32'(st_r.term_ref[i]), st_r.wdata, st_r.wstrb);
                            st_nxt.term_ref[i] = wr_val[RW-1:0];
                        end
                    end
                    if (!wr_hit) begin
                        st_nxt.bresp = ama_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // a new write waits until its response has been taken
        st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;

        // read channel
        if (s_axi_arvalid && st_r.arready) begin
            rd_hit = 1'b1;
            case (s_axi_araddr)
                ama_pkg::ADDR_CTRL:       rd_word = ctrl_word;
                ama_pkg::ADDR_REF_MASK:   rd_word = 32'(st_r.ref_mask);
                ama_pkg::ADDR_LOGIC_MASK: rd_word = 32'(st_r.logic_mask);
                ama_pkg::ADDR_ASSIGNED:   rd_word = 32'(st_r.assigned);
                ama_pkg::ADDR_SPEED:      rd_word = 32'(st_r.speed);
                ama_pkg::ADDR_STATUS: begin
                    rd_word[ama_pkg::STAT_MANUAL_BIT]  = st_r.own != ama_pkg::OWN_AUTO;
                    rd_word[ama_pkg::STAT_WIRED_BIT]   = st_r.wired_man;
                    rd_word[ama_pkg::STAT_LATCHED_BIT] = st_r.latched;
                    rd_word[ama_pkg::STAT_IDX_LSB +: IW] = st_r.idx;
                end
                default: begin
                    rd_hit = 1'b0;
                    for (int i = 0; i < N; i++) begin
                        if (s_axi_araddr == term_addr(i)) begin
                            rd_hit  = 1'b1;
                            rd_word = 32'(st_r.term_ref[i]);
                        end
                    end
                end
            endcase
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_word;
            st_nxt.rresp  = rd_hit ? ama_pkg::RESP_OKAY : ama_pkg::RESP_SLVERR;
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        st_nxt.arready = !st_nxt.rvalid;

        for (int i = 0; i < N; i++) begin
            eligible[i] = tog_rise[i] && !term_legacy[i] && st_r.ref_mask[i]
                && st_r.logic_mask[i] && !st_r.assigned[i] && !term_comm_loss[i]
                && ((local_owned & ~onehot(IW'(i))) == '0);
        end

        for (int i = N - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                grant_term = 1'b1;
                grant_idx  = IW'(i);
            end
        end

        case (st_r.own)
            ama_pkg::OWN_TERM: begin
                release_now = tog_rise[st_r.idx] || !st_r.ref_mask[st_r.idx]
                    || !st_r.logic_mask[st_r.idx] || term_logout[st_r.idx]
                    || term_comm_loss[st_r.idx]
                    || ((local_owned & ~onehot(st_r.idx)) != '0);
            end
            ama_pkg::OWN_WIRED: begin
                // wired release on input drop or local
                release_now = !am_level || (local_owned != '0);
            end
            default: begin
                release_now = 1'b0;
            end
        endcase

        if (restore) begin
            release_now            = st_r.own != ama_pkg::OWN_AUTO;
            st_nxt.ctrl            = ama_pkg::ama_ctrl_s'(RST_CTRL_SLICE);
            st_nxt.ref_mask        = ama_pkg::RST_REF_MASK[N-1:0];
            st_nxt.logic_mask      = ama_pkg::RST_LOGIC_MASK[N-1:0];
            st_nxt.assigned        = ama_pkg::RST_ASSIGNED[N-1:0];
        end

        // another owner ends use of the latched value
        if (ref_claim) begin
            st_nxt.latched = 1'b0;
        end

        if (release_now) begin
            // back to auto, keep latched value
            st_nxt.own     = ama_pkg::OWN_AUTO;
            st_nxt.latched = 1'b1;
        end else if (st_r.own == ama_pkg::OWN_AUTO && !restore) begin
            // grants only while nobody holds manual
            if (grant_term) begin
                st_nxt.own       = ama_pkg::OWN_TERM;
                st_nxt.idx       = grant_idx;
                st_nxt.latched   = 1'b0;
                st_nxt.latch_val = st_r.speed;
                if (st_r.ctrl.preload_en) begin
                    st_nxt.term_ref[grant_idx] = auto_ref;
                end
            end else if (am_rise && local_owned == '0) begin
                st_nxt.own       = ama_pkg::OWN_WIRED;
                st_nxt.latched   = 1'b0;
                st_nxt.latch_val = st_r.speed;
            end
        end

        wired_val = (int'(st_r.ctrl.wsel) < ama_pkg::WSRC_NUM)
            ? wired_src[st_r.ctrl.wsel] : wired_src[ama_pkg::WSRC_AIN1];

        case (st_nxt.own)
            ama_pkg::OWN_TERM:  st_nxt.speed = st_nxt.term_ref[st_nxt.idx];
            ama_pkg::OWN_WIRED: st_nxt.speed = wired_val;
            default:            st_nxt.speed = st_nxt.latched ? st_nxt.latch_val : auto_ref;
        endcase

        // per-terminal indication only for the holder
        st_nxt.term_man  = (st_nxt.own == ama_pkg::OWN_TERM) ? onehot(st_nxt.idx) : '0;
        st_nxt.wired_man = st_nxt.own == ama_pkg::OWN_WIRED;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r            <= '0;
            st_r.ctrl       <= ama_pkg::ama_ctrl_s'(RST_CTRL_SLICE);
            st_r.ref_mask   <= ama_pkg::RST_REF_MASK[N-1:0];
            st_r.logic_mask <= ama_pkg::RST_LOGIC_MASK[N-1:0];
            st_r.assigned   <= ama_pkg::RST_ASSIGNED[N-1:0];
            for (int i = 0; i < N; i++) begin
                st_r.term_ref[i] <= ama_pkg::RST_TERM_REF[RW-1:0];
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign s_axi_rvalid  = st_r.rvalid;
    assign speed_ref     = st_r.speed;
    assign term_manual   = st_r.term_man;
    assign wired_manual  = st_r.wired_man;
endmodule

/* rtl/ama_pkg.sv */
// constants and types shared by the auto/manual reference arbiter
package ama_pkg;

    // data widths and port count
    localparam int REF_W   = 16;
    localparam int ADDR_W  = 8;
    localparam int NPORT   = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_REF_MASK   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_LOGIC_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ASSIGNED   = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_SPEED      = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_TERM_REF   = 8'h20;
    localparam logic [ADDR_W-1:0] TERM_REF_STRIDE = 8'h04;

    // control register fields
    localparam int CTRL_PRELOAD_BIT = 0;
    localparam int CTRL_SEL_LSB     = 1;
    localparam int CTRL_SEL_W       = 3;
    localparam int CTRL_RESTORE_BIT = 8;

    // status register fields
    localparam int STAT_MANUAL_BIT  = 0;
    localparam int STAT_WIRED_BIT   = 1;
    localparam int STAT_LATCHED_BIT = 2;
    localparam int STAT_IDX_LSB     = 4;

    // reset values
    localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
    localparam logic [31:0] RST_REF_MASK   = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_LOGIC_MASK = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_ASSIGNED   = 32'h0000_0000;
    localparam logic [31:0] RST_TERM_REF   = 32'h0000_0000;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // wired manual source choices
    typedef enum logic [2:0] {
        WSRC_AIN1  = 3'b000,
        WSRC_AIN2  = 3'b001,
        WSRC_MOP   = 3'b010,
        WSRC_AIN3  = 3'b011,
        WSRC_PULSE = 3'b100,
        WSRC_ENC   = 3'b101
    } ama_wsrc_e;
    localparam int WSRC_NUM = 6;

    // who owns the reference
    typedef enum logic [1:0] {
        OWN_AUTO  = 2'b00,
        OWN_TERM  = 2'b01,
        OWN_WIRED = 2'b10
    } ama_own_e;

    // software controls
    typedef struct packed {
        logic      preload_en;
        ama_wsrc_e wsel;
    } ama_ctrl_s;

endpackage

/* rtl/ama_edge_sync.sv */
// two-flop synchroniser with rising-edge detect for pin inputs
module ama_edge_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // pins
    input  wire logic [W-1:0] din,
    // synchronised outputs
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } ama_sync_s;

    ama_sync_s st_r;
    ama_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // only s2 and s3 are read; s1 may be metastable
    assign level = st_r.s2;
    assign rise  = st_r.s2 & ~st_r.s3;
endmodule

/* bench/ama_term_model.sv */
// partner model: operator terminal buttons and the wired auto/manual switch
module ama_term_model #(
    parameter int N = 4
) (
    // clock
    input  wire logic         aclk,
    // bench commands
    input  wire logic [N-1:0] press,
    input  wire logic         wired_on,
    // pins
    output logic      [N-1:0] term_toggle,
    output logic              am_input
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N-1:0][2:0] hold_r = '0;
    always_ff @(posedge aclk) begin
        for (int i = 0; i < N; i++) begin
            if (press[i]) hold_r[i] <= 3'h4;
            else if (hold_r[i] != 3'h0) hold_r[i] <= hold_r[i] - 3'h1;
        end
    end
    // pulse outlasts the pin synchroniser so the edge is never missed
    always_comb begin
        for (int i = 0; i < N; i++) term_toggle[i] = (hold_r[i] != 3'h0);
    end
    assign am_input = wired_on;
endmodule

/* bench/ama_arbiter_sva.sv */
// checker for the auto/manual reference arbiter
module ama_arbiter_sva #(
    parameter int N = 4
) (
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         s_axi_bvalid,
    input wire logic         s_axi_bready,
    input wire logic         s_axi_rvalid,
    input wire logic         s_axi_rready,
    input wire logic [N-1:0] term_legacy,
    input wire logic [N-1:0] term_comm_loss,
    input wire logic [N-1:0] term_logout,
    input wire logic [N-1:0] local_owned,
    input wire logic         ref_claim,
    input wire logic [15:0]  auto_ref,
    input wire logic         am_input,
    input wire logic [15:0]  speed_ref,
    input wire logic [N-1:0] term_manual,
    input wire logic         wired_manual
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic held;
    assign held = (|term_manual) || wired_manual;
    a_single_holder: assert property ($onehot0({term_manual, wired_manual}))
        else $error("more than one manual holder");
    a_grant_exclusive: assert property (held && $past(held) |-> $stable({term_manual, wired_manual}))
        else $error("manual granted while held");
    a_local_refuse: assert property ($rose(|term_manual) |-> ($past(local_owned) & ~term_manual) == '0)
        else $error("manual granted under foreign local");
    a_legacy_never: assert property ((term_manual & ~$past(term_manual) & $past(term_legacy)) == '0)
        else $error("legacy terminal granted");
    a_comm_release: assert property (|(term_manual & term_comm_loss) |-> ##[1:2] term_manual == '0)
        else $error("comm loss kept manual");
    a_logout_release: assert property (|(term_manual & term_logout) |-> ##[1:2] term_manual == '0)
        else $error("logout kept manual");
    a_local_revoke: assert property (held && (local_owned & ~term_manual) != '0 |-> ##[1:2] !held)
        else $error("foreign local kept manual");
    a_wired_release: assert property (wired_manual && !am_input |-> ##[1:5] !wired_manual)
        else $error("wired manual kept after release");
    a_claim_auto: assert property (ref_claim && !held |-> ##[1:2] speed_ref == auto_ref)
        else $error("reference ownership change ignored");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    c_wired: cover property ($rose(wired_manual));
    c_term: cover property ($rose(term_manual[1]));
    c_claim: cover property (ref_claim && !held);
endmodule
bind ama_arbiter ama_arbiter_sva #(.N(N)) chk_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .term_legacy(term_legacy), .term_comm_loss(term_comm_loss),
    .term_logout(term_logout), .local_owned(local_owned), .ref_claim(ref_claim),
    .auto_ref(auto_ref), .am_input(am_input), .speed_ref(speed_ref),
    .term_manual(term_manual), .wired_manual(wired_manual));

/* bench/ama_arbiter_bench.sv */
// self-checking bench for the auto/manual reference arbiter
module ama_arbiter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, am_input, wired_manual;
    logic [1:0] bresp, rresp, rs_v;
    logic [31:0] rdata, rd_v;
    logic [3:0] press = '0, legacy = '0, closs = '0, logout = '0, local_own = '0;
    logic [3:0] term_toggle, term_manual;
    logic wired_on = 1'b0, ref_claim = 1'b0;
    logic [15:0] auto_ref = 16'h1234, speed_ref;
    logic [5:0][15:0] wired_src;
    int failures = 0, comparisons = 0;
    assign wired_src = {16'h6606, 16'h5505, 16'h4404, 16'h3303, 16'h2202, 16'h1101};
    always #12.5 aclk = ~aclk;
    ama_arbiter #(.N(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .term_toggle(term_toggle), .am_input(am_input), .term_legacy(legacy),
        .term_comm_loss(closs), .term_logout(logout), .local_owned(local_own),
        .ref_claim(ref_claim), .auto_ref(auto_ref), .wired_src(wired_src),
        .speed_ref(speed_ref), .term_manual(term_manual), .wired_manual(wired_manual));
    ama_term_model #(.N(4)) part_u (.aclk(aclk), .press(press), .wired_on(wired_on),
        .term_toggle(term_toggle), .am_input(am_input));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rs_v = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd_v = rdata;
        rs_v = rresp;
    endtask
    // pin edge is seen three edges on, grant one edge later
    task automatic hit(input logic [3:0] m);
        @(posedge aclk) press <= m;
        @(posedge aclk) press <= '0;
        repeat (8) @(posedge aclk);
    endtask
    task automatic wire_sw(input logic on);
        @(posedge aclk) wired_on <= on;
        repeat (8) @(posedge aclk);
    endtask
    task automatic cause(input int c, input logic on);
        @(posedge aclk);
        case (c)
            0: wr(ama_pkg::ADDR_REF_MASK, on ? 32'h0000_000D : 32'h0000_000F);
            1: wr(ama_pkg::ADDR_LOGIC_MASK, on ? 32'h0000_000D : 32'h0000_000F);
            2: wr(ama_pkg::ADDR_ASSIGNED, on ? 32'h0000_0002 : 32'h0000_0000);
            3: legacy <= on ? 4'h2 : 4'h0;
            4: local_own <= on ? 4'h4 : 4'h0;
            5: closs <= on ? 4'h2 : 4'h0;
            6: logout <= on ? 4'h2 : 4'h0;
            default: if (on) wr(ama_pkg::ADDR_CTRL, 32'h0000_0100);
        endcase
    endtask
    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        for (int k = 0; k < 4; k++) begin
            rd(ama_pkg::ADDR_CTRL + 8'(4 * k));
            chk(rd_v, (k == 1 || k == 2) ? 32'h0000_000F : 32'h0000_0000);
        end
        rd(8'hFC);
        chk(32'(rs_v), 32'(ama_pkg::RESP_SLVERR));
        chk(rd_v, 32'h0000_0000);
        wr(8'hFC, 32'h0000_0001);
        chk(32'(rs_v), 32'(ama_pkg::RESP_SLVERR));
        wr(ama_pkg::ADDR_CTRL, 32'h0000_0001);
        chk(32'(rs_v), 32'(ama_pkg::RESP_OKAY));
        wr(ama_pkg::ADDR_TERM_REF + 8'h08, 32'h0000_0BBB);
        hit(4'h4);
        chk(term_manual, 4'h4);
        chk(speed_ref, 16'h1234);
        rd(ama_pkg::ADDR_TERM_REF + 8'h08);
        chk(rd_v, 32'h0000_1234);
        @(posedge aclk) auto_ref <= 16'h5678;
        hit(4'h4);
        chk({term_manual, speed_ref}, {4'h0, 16'h1234});
        @(posedge aclk) ref_claim <= 1'b1;
        @(posedge aclk) ref_claim <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(speed_ref, 16'h5678);
        wr(ama_pkg::ADDR_CTRL, 32'h0000_0000);
        wr(ama_pkg::ADDR_TERM_REF + 8'h04, 32'h0000_0BBB);
        hit(4'h2);
        chk(speed_ref, 16'h0BBB);
        rd(ama_pkg::ADDR_TERM_REF + 8'h04);
        chk(rd_v, 32'h0000_0BBB);
        hit(4'h9);
        wire_sw(1'b1);
        chk({term_manual, wired_manual}, {4'h2, 1'b0});
        wire_sw(1'b0);
        hit(4'h2);
        hit(4'h9);
        chk(term_manual, 4'h1);
        hit(4'h1);
        for (int c = 0; c < 6; c++) begin
            cause(c, 1'b1);
            hit(4'h2);
            chk(term_manual, 4'h0);
            cause(c, 1'b0);
        end
        for (int c = 0; c < 8; c++) begin
            if (c == 2 || c == 3) continue;
            hit(4'h2);
            chk(term_manual, 4'h2);
            cause(c, 1'b1);
            repeat (6) @(posedge aclk);
            chk(term_manual, 4'h0);
            cause(c, 1'b0);
            repeat (8) @(posedge aclk);
            chk(term_manual, 4'h0);
        end
        // selector codes 6 and 7 fall back to the first analog input
        for (int k = 0; k < 8; k++) begin
            wr(ama_pkg::ADDR_CTRL, 32'(k) << 1);
            wire_sw(1'b1);
            chk({wired_manual, speed_ref}, {1'b1, 16'(16'h1101 * ((k < 6) ? k + 1 : 1))});
            wire_sw(1'b0);
            chk(wired_manual, 1'b0);
        end
        wire_sw(1'b1);
        @(posedge aclk) local_own <= 4'h1;
        repeat (6) @(posedge aclk);
        chk(wired_manual, 1'b0);
        @(posedge aclk) local_own <= 4'h0;
        repeat (8) @(posedge aclk);
        chk(wired_manual, 1'b0);
        stop_test();
    end
endmodule
